// *** rtl/rrn_addr_gen.sv ***
// Purpose: Forms the 12-bit data address of a byte-oriented operand.
// Assumes: Extended-set index base is supplied by the core.
// Notes: Purely combinational.
`timescale 1ns/1ps
module rrn_addr_gen (
    input  wire logic [7:0]  i_faddr,
    input  wire logic        i_bank_sel,
    input  wire logic        i_ext_en,
    input  wire logic [3:0]  i_bank_ptr,
    input  wire logic [11:0] i_index_base,
    output logic      [11:0] o_addr,
    output logic             o_indexed
);
    wire        use_idx;
    wire [11:0] acc_addr;
    wire [11:0] idx_addr;

    // The access bank splits so that low addresses hit bank 0 and high ones the special bank.
    assign use_idx   = !i_bank_sel && i_ext_en && (i_faddr <= rrn_pkg::IDX_LIMIT);
    assign acc_addr  = (i_faddr < rrn_pkg::ACC_SPLIT) ? {rrn_pkg::ACC_LOW_BANK, i_faddr}
                                                    : {rrn_pkg::ACC_HIGH_BANK, i_faddr};
    assign idx_addr  = i_index_base + {4'h0, i_faddr};
    assign o_indexed = use_idx;
    assign o_addr    = use_idx ? idx_addr
                     : i_bank_sel ? {i_bank_ptr, i_faddr}
                     : acc_addr;
endmodule : rrn_addr_gen

// *** rtl/rrn_exec.sv ***
// Purpose: Executes the rotate_right_plain_op instruction across four phases.
// Assumes: Data memory answers a read within the same phase it is requested.
// Notes: The carry flag is never driven; only N and Z get write strobes.
`timescale 1ns/1ps
module rrn_exec (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    input  wire logic [15:0] i_opcode,
    input  wire logic        i_ext_en,
    input  wire logic [3:0]  i_bank_pointer_register,
    input  wire logic [11:0] i_index_base,
    input  wire logic [7:0]  i_mem_rdata,
    output logic      [3:0]  o_phase,
    output logic             o_match,
    output logic             o_mem_rd,
    output logic      [11:0] o_mem_addr,
    output logic             o_mem_wr,
    output logic      [7:0]  o_mem_wdata,
    output logic             o_w_wr,
    output logic      [7:0]  o_w_data,
    output logic             o_flag_wr,
    output logic             o_flag_n,
    output logic             o_flag_z,
    output logic             o_indexed
);
    rrn_pkg::rrn_phase_t phase_q;
    rrn_pkg::rrn_phase_t phase_d;
    logic [15:0] opc_q;
    logic [7:0]  opnd_q;
    logic [7:0]  res_q;
    logic        hit_q;
    logic [7:0]  w_q;
    logic [7:0]  wdata_q;
    logic        nf_q;
    logic        zf_q;

    wire        hit_now;
    wire        dir_f;
    wire [7:0]  rot;
    wire [11:0] addr;
    wire        idx;

    always_comb begin
        case (phase_q)
            rrn_pkg::RRN_Q1: phase_d = rrn_pkg::RRN_Q2;
            rrn_pkg::RRN_Q2: phase_d = rrn_pkg::RRN_Q3;
            rrn_pkg::RRN_Q3: phase_d = rrn_pkg::RRN_Q4;
            rrn_pkg::RRN_Q4: phase_d = rrn_pkg::RRN_Q1;
            default:         phase_d = rrn_pkg::RRN_Q1;
        endcase
    end

    assign hit_now = (i_opcode[rrn_pkg::OPC_HI:rrn_pkg::OPC_LO] == rrn_pkg::OPC_PREFIX);
    assign dir_f   = opc_q[rrn_pkg::DIR_BIT];
    assign rot     = {opnd_q[0], opnd_q[7:1]};

    rrn_addr_gen u_addr (
        .i_faddr      (opc_q[7:0]),
        .i_bank_sel   (opc_q[rrn_pkg::BANK_BIT]),
        .i_ext_en     (i_ext_en),
        .i_bank_ptr   (i_bank_pointer_register),
        .i_index_base (i_index_base),
        .o_addr       (addr),
        .o_indexed    (idx)
    );

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_q <= rrn_pkg::RRN_Q1;
            opc_q   <= rrn_pkg::RESET_OPC;
            hit_q   <= 1'b0;
        end else if (i_ce) begin
            phase_q <= phase_d;
            if (phase_q == rrn_pkg::RRN_Q1) begin
                opc_q <= i_opcode;
                hit_q <= hit_now;
            end
        end
    end

    // Operand and result are staged so every data output comes from a flip-flop.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            opnd_q  <= rrn_pkg::RESET_BYTE;
            res_q   <= rrn_pkg::RESET_BYTE;
            w_q     <= rrn_pkg::RESET_BYTE;
            wdata_q <= rrn_pkg::RESET_BYTE;
            nf_q    <= 1'b0;
            zf_q    <= 1'b0;
        end else if (i_ce) begin
            if (phase_q == rrn_pkg::RRN_Q2 && hit_q) begin
                opnd_q <= i_mem_rdata;
            end
            if (phase_q == rrn_pkg::RRN_Q3 && hit_q) begin
                res_q   <= rot;
                wdata_q <= rot;
                nf_q    <= rot[7];
                zf_q    <= (rot == rrn_pkg::RESET_BYTE);
                if (!dir_f) begin
                    w_q <= rot;
                end
            end
        end
    end

    wire in_q4 = (phase_q == rrn_pkg::RRN_Q4) && hit_q;

    assign o_phase     = phase_q;
    assign o_match     = hit_q;
    assign o_mem_rd    = (phase_q == rrn_pkg::RRN_Q2) && hit_q;
    assign o_mem_addr  = hit_q ? addr : 12'h000;
    assign o_mem_wr    = in_q4 && dir_f;
    assign o_w_wr      = in_q4 && !dir_f;
    assign o_mem_wdata = wdata_q;
    assign o_w_data    = w_q;
    assign o_flag_wr   = in_q4;
    assign o_flag_n    = nf_q;
    assign o_flag_z    = zf_q;
    assign o_indexed   = hit_q && idx;

    property p_rot_value;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_ce && phase_q == rrn_pkg::RRN_Q3 && hit_q) |=>
            (res_q == {$past(opnd_q[0]), $past(opnd_q[7:1])})
            && (o_flag_z == (res_q == rrn_pkg::RESET_BYTE));
    endproperty
    a_rot_value: assert property (p_rot_value) else $error("Rotate result wrong.");

    property p_w_only;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_flag_wr && !dir_f) |-> (o_w_wr && !o_mem_wr && o_w_data == res_q);
    endproperty
    a_w_only: assert property (p_w_only) else $error("Working write wrong.");

    property p_f_back;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_flag_wr && dir_f) |-> (o_mem_wr && !o_w_wr && o_mem_wdata == res_q);
    endproperty
    a_f_back: assert property (p_f_back) else $error("Write-back wrong.");

    property p_access;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_mem_rd && !opc_q[rrn_pkg::BANK_BIT] && !idx && opc_q[7:0] < rrn_pkg::ACC_SPLIT)
            |-> (o_mem_addr == {rrn_pkg::ACC_LOW_BANK, opc_q[7:0]});
    endproperty
    a_access: assert property (p_access) else $error("Access bank address wrong.");

    property p_banked;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_mem_rd && opc_q[rrn_pkg::BANK_BIT])
            |-> (o_mem_addr == {i_bank_pointer_register, opc_q[7:0]}) && !o_indexed;
    endproperty
    a_banked: assert property (p_banked) else $error("Banked address wrong.");

    property p_indexed;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_match && !opc_q[rrn_pkg::BANK_BIT] && i_ext_en && opc_q[7:0] <= rrn_pkg::IDX_LIMIT)
            |-> o_indexed;
    endproperty
    a_indexed: assert property (p_indexed) else $error("Indexed mode missed.");

    property p_phase_walk;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_ce && o_mem_rd) ##1 i_ce[*2] |-> o_flag_wr;
    endproperty
    a_phase_walk: assert property (p_phase_walk) else $error("Phase order wrong.");

    property p_decode;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_ce && phase_q == rrn_pkg::RRN_Q1) |=> (o_match == $past(hit_now));
    endproperty
    a_decode: assert property (p_decode) else $error("Decode wrong.");

    // Carry has no port here, so the flag strobe may only ever carry N and Z of the result.
    property p_flag_src;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_flag_wr |-> (o_flag_n == o_mem_wdata[7])
            && (o_flag_z == (o_mem_wdata == rrn_pkg::RESET_BYTE));
    endproperty
    a_flag_src: assert property (p_flag_src) else $error("Flag value wrong.");

    property p_one_dest;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        !(o_mem_wr && o_w_wr);
    endproperty
    a_one_dest: assert property (p_one_dest) else $error("Both destinations written.");

    // A write-back instruction must leave the working register exactly as it was.
    property p_w_hold;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        !(i_ce && phase_q == rrn_pkg::RRN_Q3 && hit_q && !dir_f) |=> $stable(o_w_data);
    endproperty
    a_w_hold: assert property (p_w_hold) else $error("Working value disturbed.");

    property p_access_high;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_mem_rd && !opc_q[rrn_pkg::BANK_BIT] && !idx && opc_q[7:0] >= rrn_pkg::ACC_SPLIT)
            |-> (o_mem_addr == {rrn_pkg::ACC_HIGH_BANK, opc_q[7:0]});
    endproperty
    a_access_high: assert property (p_access_high) else $error("Upper access address wrong.");

    // The index sum wraps at twelve bits, the same as the address bus itself.
    property p_idx_addr;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (o_mem_rd && o_indexed)
            |-> (o_mem_addr == i_index_base + {rrn_pkg::ACC_LOW_BANK, opc_q[7:0]});
    endproperty
    a_idx_addr: assert property (p_idx_addr) else $error("Indexed address wrong.");

    property p_not_idx;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        o_indexed |-> (!opc_q[rrn_pkg::BANK_BIT] && i_ext_en && opc_q[7:0] <= rrn_pkg::IDX_LIMIT);
    endproperty
    a_not_idx: assert property (p_not_idx) else $error("Indexed mode without cause.");

    property p_freeze;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        !i_ce |=> $stable(o_phase) && $stable(o_mem_wdata) && $stable(o_match);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved while disabled.");

    property p_foreign;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        !o_match |-> !(o_mem_rd || o_mem_wr || o_w_wr || o_flag_wr || o_indexed);
    endproperty
    a_foreign: assert property (p_foreign) else $error("Strobe without a match.");

    c_w_path: cover property (@(posedge i_clk_sys) o_w_wr);
    c_zero:   cover property (@(posedge i_clk_sys) o_flag_wr && o_flag_z);
    c_f_path: cover property (@(posedge i_clk_sys) o_mem_wr);
    c_idx:    cover property (@(posedge i_clk_sys) o_indexed && o_mem_rd);
endmodule : rrn_exec

// *** rtl/rrn_pkg.sv ***
// Purpose: Constants for the rotate-right-without-carry execution unit.
// Assumes: One instruction cycle is four clock-enabled phases on i_clk_sys.
// Notes: Opcode layout is 16 bits: 0100 00 d a ffff ffff.
// Notes on behaviour
// - The operand is rotated right by one with bit 0 moving to bit 7, only N and Z change.
// - With the direction bit at 0 the result goes to the working register only.
// - With the direction bit at 1 the result is written back to the source register.
// - With the bank bit at 0 the access bank is used unless indexed mode applies, and the bank pointer is ignored.
// - With the bank bit at 1 the bank pointer register supplies the bank.
// - Bank bit 0, extended set on and address at most 95 selects indexed literal offset mode.
package rrn_pkg;
    localparam logic [5:0]  OPC_PREFIX    = 6'h10;
    localparam int          OPC_HI        = 15;
    localparam int          OPC_LO        = 10;
    localparam int          DIR_BIT       = 9;
    localparam int          BANK_BIT      = 8;
    localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
    localparam logic [7:0]  ACC_SPLIT     = 8'h60;
    localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;
    localparam logic [3:0]  ACC_HIGH_BANK = 4'hf;
    localparam logic [7:0]  RESET_BYTE    = 8'h00;
    localparam logic [15:0] RESET_OPC     = 16'h0000;

    typedef enum logic [3:0] {
        RRN_Q1 = 4'h1,
        RRN_Q2 = 4'h2,
        RRN_Q3 = 4'h4,
        RRN_Q4 = 4'h8
    } rrn_phase_t;
endpackage : rrn_pkg

// *** verification/rrn_mem_model.sv ***
// Purpose: Behavioural data memory on the far side of the rotate unit.
// Assumes: A read is answered in the phase that asks for it.
// Notes: Outside a read the bus shows the inverse of the last byte, so a stale value never passes.
`timescale 1ns/1ps
module rrn_mem_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [11:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_q;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h00;
        end
        last_q = 8'h00;
    end
    always @(posedge i_clk_sys) begin
        if (i_rd) begin
            last_q <= mem[i_addr];
        end
        if (i_wr) begin
            mem[i_addr] <= i_wdata;
        end
    end
    assign o_rdata = i_rd ? mem[i_addr] : ~last_q;
endmodule : rrn_mem_model

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the rotate-right execution unit.
// Assumes: The clock enable is held high except inside t_freeze, so each phase is one clock.
// Notes: Operand bytes are preloaded into the memory model between instructions.
`timescale 1ns/1ps
module testbench;
    logic        i_clk_sys;
    logic        i_sys_rst;
    logic        i_ce;
    logic [15:0] i_opcode;
    logic        i_ext_en;
    logic [3:0]  i_bank_pointer_register;
    logic [11:0] i_index_base;
    logic [7:0]  i_mem_rdata;
    logic [3:0]  o_phase;
    logic        o_match;
    logic        o_mem_rd;
    logic [11:0] o_mem_addr;
    logic        o_mem_wr;
    logic [7:0]  o_mem_wdata;
    logic        o_w_wr;
    logic [7:0]  o_w_data;
    logic        o_flag_wr;
    logic        o_flag_n;
    logic        o_flag_z;
    logic        o_indexed;
    int          failures;
    int          samples_checked;

    rrn_exec dut_u (
        .i_clk_sys               (i_clk_sys),
        .i_sys_rst               (i_sys_rst),
        .i_ce                    (i_ce),
        .i_opcode                (i_opcode),
        .i_ext_en                (i_ext_en),
        .i_bank_pointer_register (i_bank_pointer_register),
        .i_index_base            (i_index_base),
        .i_mem_rdata             (i_mem_rdata),
        .o_phase                 (o_phase),
        .o_match                 (o_match),
        .o_mem_rd                (o_mem_rd),
        .o_mem_addr              (o_mem_addr),
        .o_mem_wr                (o_mem_wr),
        .o_mem_wdata             (o_mem_wdata),
        .o_w_wr                  (o_w_wr),
        .o_w_data                (o_w_data),
        .o_flag_wr               (o_flag_wr),
        .o_flag_n                (o_flag_n),
        .o_flag_z                (o_flag_z),
        .o_indexed               (o_indexed)
    );
    rrn_mem_model mem_u (.i_clk_sys(i_clk_sys), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
        .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic summarize();
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // Loads the opcode while Q4 closes, then stops mid-Q4 of that instruction.
    // The opcode is withdrawn once taken, so the next Q1 cannot run it a second time.
    task automatic run_op(input logic [15:0] op, input logic ext, input logic [3:0] bp,
                          input logic [11:0] base);
        while (o_phase !== 4'h8) @(negedge i_clk_sys);
        @(posedge i_clk_sys);
        i_opcode <= op;
        i_ext_en <= ext;
        i_bank_pointer_register <= bp;
        i_index_base <= base;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check(o_mem_rd === (op[15:10] == 6'h10), "read strobe in Q2");
        @(posedge i_clk_sys);
        i_opcode <= 16'h0000;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask : run_op

    task automatic judge(input logic d, input logic [11:0] a, input logic [7:0] v);
        logic [7:0] r;
        r = {v[0], v[7:1]};
        check(o_flag_wr === 1'b1 && o_flag_n === r[7] && o_flag_z === (r == 8'h00), "flags");
        check(o_mem_wr === d && o_w_wr === !d, "destination strobe");
        check(d || o_w_data === r, "working value");
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check(mem_u.mem[a] === (d ? r : v), "operand byte");
    endtask : judge

    task automatic run_case(input logic d, input logic a, input logic [7:0] f, input logic ext,
                            input logic [11:0] adr, input logic [7:0] v);
        mem_u.mem[adr] = v;
        run_op({6'h10, d, a, f}, ext, 4'h3, 12'h200);
        check(o_match === 1'b1 && o_mem_addr === adr, "operand address");
        check(o_indexed === (!a && ext && f <= 8'h5f), "indexed mode flag");
        judge(d, adr, v);
    endtask : run_case

    task automatic t_foreign();
        run_op(16'h4480, 1'b0, 4'h3, 12'h200);
        check(o_match === 1'b0 && o_flag_wr === 1'b0 && o_mem_wr === 1'b0 && o_w_wr === 1'b0,
              "foreign opcode strobes");
    endtask : t_foreign

    // Runs one write-back, then holds the clock enable low and expects nothing to move.
    task automatic t_freeze();
        logic [3:0] ph;
        mem_u.mem[12'h020] = 8'h81;
        run_op(16'h4220, 1'b0, 4'h3, 12'h200);
        @(posedge i_clk_sys);
        i_ce <= 1'b0;
        @(negedge i_clk_sys);
        ph = o_phase;
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check(o_phase === ph && o_mem_wdata === 8'hc0 && mem_u.mem[12'h020] === 8'hc0,
              "state frozen while clock enable is low");
        @(posedge i_clk_sys);
        i_ce <= 1'b1;
    endtask : t_freeze

    initial begin
        #20000;
        failures++;
        summarize();
    end

    initial begin
        failures = 0;
        samples_checked = 0;
        i_sys_rst = 1'b1;
        i_ce = 1'b1;
        i_opcode = 16'h0000;
        i_ext_en = 1'b0;
        i_bank_pointer_register = 4'h0;
        i_index_base = 12'h000;
        repeat (16) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        run_case(1'b0, 1'b0, 8'h80, 1'b0, 12'hf80, 8'hd7);
        run_case(1'b1, 1'b1, 8'h12, 1'b0, 12'h312, 8'h01);
        run_case(1'b1, 1'b0, 8'h5f, 1'b0, 12'h05f, 8'h00);
        run_case(1'b1, 1'b0, 8'h5f, 1'b1, 12'h25f, 8'h02);
        run_case(1'b0, 1'b0, 8'h60, 1'b1, 12'hf60, 8'h3c);
        run_case(1'b1, 1'b1, 8'h5f, 1'b1, 12'h35f, 8'haa);
        t_freeze();
        t_foreign();
        summarize();
    end
endmodule : testbench
